// ==== hdl/tbk_timer_bank.sv ====
// five counter/timers: tick selection, counting and byte access
// =============================================================
// Functional notes
// - five sixteen-bit counter/timers in one bank
// - timers 0/1: 13, 16, 8-reload, split modes
// - timer 2: reload, capture, first port baud
// - timer 3: reload only, no capture/baud
// - timer 4 like 2, baud for second port
// - timer mode increments once per tick
// - tick is clock/1 or clock/12 per timer
// - counter mode increments on falling pin edges
// - events counted up to half clock rate
// - count readable as low and high bytes
`timescale 1ns/10ps
module tbk_timer_bank #(
    parameter int NUM = tbk_pkg::NUM_TIMERS
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [4:0] timerTickDivideSelects,   // 1 = clock/1, 0 = clock/12
    input wire logic [4:0] counterSelect,            // 1 = count pin edges (ignored for timer 3)
    input wire logic [4:0] runEnable,                // run per timer
    input wire logic [4:0] eventPin,                 // external event inputs
    input wire logic [1:0] mode0,                    // timer 0 mode
    input wire logic [1:0] mode1,                    // timer 1 mode
    input wire logic [1:0] mode2,                    // timer 2 function
    input wire logic [1:0] mode3,                    // timer 3 function (reload only)
    input wire logic [1:0] mode4,                    // timer 4 function
    input wire logic [4:0] captureStrobe,            // capture request per timer
    input wire logic [4:0] loadStrobe,               // software load of count
    input wire logic [15:0] loadValue,               // value for load / reload
    input wire logic [4:0] reloadWrite,              // write reload register
    input wire logic [2:0] readSelect,               // timer to view
    output logic [7:0] readLow,                      // low byte of selected count
    output logic [7:0] readHigh,                     // high byte of selected count
    output logic [4:0] overflow,                     // one-cycle overflow pulses
    output logic firstSerialPortBaud,                // timer 2 baud pulse
    output logic secondSerialPortBaud,               // timer 4 baud pulse
    output logic [15:0] capture2,                    // timer 2 captured count
    output logic [15:0] capture4                     // timer 4 captured count
);
    // =========================================================
    // elaboration check
    if (NUM != 5) begin : g_bad_num
        $error("bank is built for exactly five timers");
    end

    // =========================================================
    // shared clock/12 prescaler
    logic [3:0] preCount;    // prescale counter
    logic slowTick;          // one-cycle enable every twelve clocks
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            preCount <= 4'h0;
        end else if (preCount == tbk_pkg::SLOW_TICK_LAST) begin
            preCount <= 4'h0;
        end else begin
            preCount <= preCount + 4'h1;
        end
    end
    assign slowTick = (preCount == tbk_pkg::SLOW_TICK_LAST);

    // =========================================================
    // per-timer datapath
    logic [15:0] count [5];     // count registers
    logic [15:0] reload [5];    // reload registers
    logic [4:0] step;           // increment enable this cycle
    logic [4:0] syncA;          // first synchroniser stage
    logic [4:0] syncB;          // second synchroniser stage
    logic [4:0] syncPrev;       // previous synchronised sample
    logic [1:0] modeOf [5];

    assign modeOf[0] = mode0;
    assign modeOf[1] = mode1;
    assign modeOf[2] = mode2;
    assign modeOf[3] = (mode3 == tbk_pkg::TBK_AR_IDLE) ? mode3 : tbk_pkg::TBK_AR_RELOAD;
    assign modeOf[4] = mode4;

    genvar gi;
    generate
        for (gi = 0; gi < 5; gi++) begin : g_timer
            // pin sampling; only syncB reads syncA
            always_ff @(posedge sys_clk) begin
                if (rst) begin
                    syncA[gi] <= 1'b1;
                    syncB[gi] <= 1'b1;
                    syncPrev[gi] <= 1'b1;
                end else begin
                    syncA[gi] <= eventPin[gi];
                    syncB[gi] <= syncA[gi];
                    syncPrev[gi] <= syncB[gi];
                end
            end

            // tick source: falling edge, clock, or clock/12; timer 3 is timer-only
            always_comb begin
                if (counterSelect[gi] && gi != 3) begin
                    step[gi] = runEnable[gi] && syncPrev[gi] && !syncB[gi];
                end else begin
                    step[gi] = runEnable[gi] && (timerTickDivideSelects[gi] || slowTick);
                end
            end

            // reload register write
            always_ff @(posedge sys_clk) begin
                if (rst) begin
                    reload[gi] <= tbk_pkg::RELOAD_RESET;
                end else if (reloadWrite[gi]) begin
                    reload[gi] <= loadValue;
                end
            end

            // count update per mode
            always_ff @(posedge sys_clk) begin
                if (rst) begin
                    count[gi] <= tbk_pkg::COUNT_RESET;
                    overflow[gi] <= 1'b0;
                end else if (loadStrobe[gi]) begin
                    count[gi] <= loadValue;
                    overflow[gi] <= 1'b0;
                end else if (gi < 2) begin
                    overflow[gi] <= 1'b0;
                    if (step[gi]) begin
                        case (modeOf[gi])
                            tbk_pkg::TBK_MODE_13BIT: begin
                                // high byte holds 8 msbs, low five bits of low byte hold lsbs
                                if (count[gi][15:8] == 8'hff && count[gi][4:0] == 5'h1f) begin
                                    overflow[gi] <= 1'b1;
                                end
                                if (count[gi][4:0] == 5'h1f) begin
                                    count[gi] <= {count[gi][15:8] + 8'h01, count[gi][7:5], 5'h00};
                                end else begin
                                    count[gi] <= {count[gi][15:5], count[gi][4:0] + 5'h01};
                                end
                            end
                            tbk_pkg::TBK_MODE_8RELOAD: begin
                                if (count[gi][7:0] == 8'hff) begin
                                    count[gi] <= {count[gi][15:8], count[gi][15:8]};
                                    overflow[gi] <= 1'b1;
                                end else begin
                                    count[gi] <= {count[gi][15:8], count[gi][7:0] + 8'h01};
                                end
                            end
                            tbk_pkg::TBK_MODE_SPLIT: begin
                                // timer 0 runs two 8-bit halves; timer 1 holds in this mode
                                if (gi == 0) begin
                                    count[gi] <= {count[gi][15:8] + 8'h01, count[gi][7:0] + 8'h01};
                                    overflow[gi] <= (count[gi][7:0] == 8'hff);
                                end
                            end
                            default: begin // 16-bit
                                count[gi] <= count[gi] + 16'h0001;
                                overflow[gi] <= (count[gi] == 16'hffff);
                            end
                        endcase
                    end
                end else begin
                    overflow[gi] <= 1'b0;
                    if (step[gi] && modeOf[gi] != tbk_pkg::TBK_AR_IDLE) begin
                        if (count[gi] == 16'hffff) begin
                            // reload on overflow in reload, capture and baud functions
                            count[gi] <= reload[gi];
                            overflow[gi] <= 1'b1;
                        end else begin
                            count[gi] <= count[gi] + 16'h0001;
                        end
                    end
                end
            end
        end
    endgenerate

    // =========================================================
    // capture registers; timer 3 has none
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            capture2 <= tbk_pkg::COUNT_RESET;
            capture4 <= tbk_pkg::COUNT_RESET;
        end else begin
            if (captureStrobe[2] && mode2 == tbk_pkg::TBK_AR_CAPTURE) begin
                capture2 <= count[2];
            end
            if (captureStrobe[4] && mode4 == tbk_pkg::TBK_AR_CAPTURE) begin
                capture4 <= count[4];
            end
        end
    end

    // =========================================================
    // baud pulses: timer 2 to first port, timer 4 to second
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            firstSerialPortBaud <= 1'b0;
            secondSerialPortBaud <= 1'b0;
        end else begin
            // a software load beats the wrap, so no baud pulse is sent for it
            firstSerialPortBaud <= step[2] && !loadStrobe[2] && mode2 == tbk_pkg::TBK_AR_BAUD
                && count[2] == 16'hffff;
            secondSerialPortBaud <= step[4] && !loadStrobe[4] && mode4 == tbk_pkg::TBK_AR_BAUD
                && count[4] == 16'hffff;
        end
    end

    // =========================================================
    // byte view of a selected count
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            readLow <= 8'h00;
            readHigh <= 8'h00;
        end else if (readSelect < 3'h5) begin
            readLow <= count[readSelect][7:0];
            readHigh <= count[readSelect][15:8];
        end else begin
            readLow <= 8'h00;
            readHigh <= 8'h00;
        end
    end

    // =========================================================
    // assertions
    a_fast_tick_count: assert property (@(posedge sys_clk) disable iff (rst)
        (runEnable[1] && !counterSelect[1] && timerTickDivideSelects[1] && mode1 == 2'b01
         && !loadStrobe[1] && !$past(rst)) |=> count[1] == $past(count[1]) + 16'h0001)
        else $error("fast tick did not add one");
    a_slow_tick_period: assert property (@(posedge sys_clk) disable iff (rst)
        slowTick |=> !slowTick [*8] ##1 !slowTick [*3] ##1 slowTick)
        else $error("slow tick period is not twelve");
    a_fall_edge_step: assert property (@(posedge sys_clk) disable iff (rst)
        (counterSelect[0] && runEnable[0] && $fell(syncB[0])) |-> step[0])
        else $error("falling edge not counted");
    a_no_rise_step: assert property (@(posedge sys_clk) disable iff (rst)
        (counterSelect[0] && syncB[0]) |-> !step[0])
        else $error("counted without falling edge");
    a_reload_wrap: assert property (@(posedge sys_clk) disable iff (rst)
        (step[3] && count[3] == 16'hffff && !loadStrobe[3] && mode3 != 2'b11) |=> count[3] == $past(reload[3]))
        else $error("timer 3 reload missed");
    a_baud_second: assert property (@(posedge sys_clk) disable iff (rst)
        secondSerialPortBaud |-> $past(count[4]) == 16'hffff)
        else $error("second port baud without wrap");
    a_capture_hold: assert property (@(posedge sys_clk) disable iff (rst)
        (captureStrobe[2] && mode2 == 2'b01) |=> capture2 == $past(count[2]))
        else $error("capture lost");
    a_byte_view: assert property (@(posedge sys_clk) disable iff (rst)
        (readSelect == 3'h0) |=> {readHigh, readLow} == $past(count[0]))
        else $error("byte view mismatch");
    c_pin_count: cover property (@(posedge sys_clk) counterSelect[0] && step[0]);
    c_slow_step: cover property (@(posedge sys_clk) !timerTickDivideSelects[2] && step[2]);
    c_overflow16: cover property (@(posedge sys_clk) overflow[4]);
endmodule // tbk_timer_bank

// ==== hdl/tbk_pkg.sv ====
// shared constants for the five-timer tick and count bank
package tbk_pkg;
    // =========================================================
    // bank shape
    localparam int NUM_TIMERS = 5;
    localparam int COUNT_WIDTH = 16;
    // =========================================================
    // tick timing
    localparam int SYS_CLK_HZ = 10000000;
    localparam int SLOW_TICK_DIVIDE = 12;
    localparam logic [3:0] SLOW_TICK_LAST = 4'(SLOW_TICK_DIVIDE - 1);
    // =========================================================
    // reset values
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] RELOAD_RESET = 16'h0000;
    // =========================================================
    // timer 0/1 modes
    typedef enum logic [1:0] {
        TBK_MODE_13BIT = 2'b00,
        TBK_MODE_16BIT = 2'b01,
        TBK_MODE_8RELOAD = 2'b10,
        TBK_MODE_SPLIT = 2'b11
    } tbk_mode_type;
    // =========================================================
    // timer 2-4 modes
    typedef enum logic [1:0] {
        TBK_AR_RELOAD = 2'b00,
        TBK_AR_CAPTURE = 2'b01,
        TBK_AR_BAUD = 2'b10,
        TBK_AR_IDLE = 2'b11
    } tbk_ar_type;
endpackage

// ==== verification/tbk_event_source.sv ====
// behavioural model of the outside circuitry that drives the event pins
`timescale 1ns/10ps
module tbk_event_source (
    input wire logic sys_clk,
    output logic [4:0] eventPin
);
    // =========================================================
    // pin state and random hold lengths
    int seed = 32'h0fae;
    // pins rest high between bursts, as a pulled-up input would
    initial eventPin = 5'h1f;
    // =========================================================
    // burst of falling edges on the masked pins
    // each level is held 2..4 clocks, so a period is never under four clocks
    task automatic burst(input logic [4:0] mask, input int k);
        int hLow;
        int hHigh;
        for (int n = 0; n < k; n++) begin
            hLow = 2 + ($unsigned($random(seed)) % 3);
            hHigh = 2 + ($unsigned($random(seed)) % 3);
            eventPin <= 5'h1f & ~mask;
            repeat (hLow) @(posedge sys_clk);
            #10 eventPin <= 5'h1f;
            repeat (hHigh) @(posedge sys_clk);
            #10;
        end
    endtask
endmodule // tbk_event_source

// ==== verification/tb.sv ====
// self-checking bench for the five-timer tick and count bank
`timescale 1ns/10ps
module tb;
    // =========================================================
    // stimulus, responses and bookkeeping
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [4:0] tds = 5'h1f, csel = 5'h00, run = 5'h00, cap = 5'h00, lds = 5'h00, rlw = 5'h00;
    logic [1:0] m0 = 2'h1, m1 = 2'h1, m2 = 2'h0, m3 = 2'h0, m4 = 2'h0;
    logic [15:0] lval = 16'h0000;
    logic [2:0] rsel = 3'h0;
    logic [4:0] evt;
    logic [7:0] rl, rh;
    logic [4:0] ovf;             // overflow pulses
    logic b1, b2;                // baud pulses to first and second port
    logic [15:0] cp2, cp4;       // captured counts
    logic [15:0] v0, total;
    int badCount = 0;
    int checks = 0;
    int seed = 32'h0fae;
    int n;
    // =========================================================
    // clock and design
    initial forever #50 sys_clk = ~sys_clk;
    tbk_timer_bank i_dut (.sys_clk(sys_clk), .rst(rst), .timerTickDivideSelects(tds), .counterSelect(csel),
        .runEnable(run), .eventPin(evt), .mode0(m0), .mode1(m1), .mode2(m2), .mode3(m3), .mode4(m4),
        .captureStrobe(cap), .loadStrobe(lds), .loadValue(lval), .reloadWrite(rlw), .readSelect(rsel),
        .readLow(rl), .readHigh(rh), .overflow(ovf), .firstSerialPortBaud(b1), .secondSerialPortBaud(b2),
        .capture2(cp2), .capture4(cp4));
    tbk_event_source i_src (.sys_clk(sys_clk), .eventPin(evt));
    // =========================================================
    // helpers
    // inputs always change 10 ns after the rising edge
    task automatic tick(input int k);
        repeat (k) @(posedge sys_clk);
        #10;
    endtask
    task automatic compare(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            badCount++;
            $display("unexpected at %0t: count %h expected %h", $time, seen, exp);
        end
    endtask
    // whole count as the two read bytes form it
    function automatic logic [15:0] cnt();
        return {rh, rl};
    endfunction
    // expected count after k clocks with fast or slow tick
    function automatic logic [15:0] expTick(input logic [15:0] v, input int k, input logic fast);
        return fast ? v + 16'(k) : v + 16'(k / 12);
    endfunction
    task automatic end_of_test();
        $display("mismatches %0d comparisons %0d", badCount, checks);
        if (badCount == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // =========================================================
    // watchdog: the whole run must end well inside this bound
    initial begin
        repeat (100000) @(posedge sys_clk);
        badCount++;
        end_of_test();
    end
    // =========================================================
    // main sequence
    initial begin
        tick(20);
        rst = 1'b0;
        // counts come out of reset at zero, byte split included
        for (int i = 0; i < 5; i++) begin
            rsel = 3'(i);
            tick(1);
            compare(cnt(), 16'h0000);
        end
        // software load lands in both bytes, no counting while stopped
        lval = 16'($random(seed));
        lds = 5'h1f;
        tick(1);
        lds = 5'h00;
        for (int i = 0; i < 5; i++) begin
            rsel = 3'(i);
            tick(2);
            compare(cnt(), lval);
        end
        // selections beyond the bank read as zero
        for (int i = 5; i < 8; i++) begin
            rsel = 3'(i);
            tick(1);
            compare(cnt(), 16'h0000);
        end
        // fast then slow tick on each of the five timers; deltas avoid prescaler phase
        run = 5'h1f;
        for (int s = 1; s >= 0; s--) begin
            tds = s[0] ? 5'h1f : 5'h00;
            for (int i = 0; i < 5; i++) begin
                rsel = 3'(i);
                tick(2);
                v0 = cnt();
                n = s[0] ? 1 + ($unsigned($random(seed)) % 40) : 12 * (1 + ($unsigned($random(seed)) % 5));
                tick(n);
                compare(cnt(), expTick(v0, n, s[0]));
            end
        end
        // counter mode on timers 0,1,2,4: single edge first, then random bursts
        csel = 5'h17;
        lval = 16'h0000;
        lds = 5'h1f;
        tick(1);
        lds = 5'h00;
        total = 16'h0000;
        for (int r = 0; r < 3; r++) begin
            n = (r == 0) ? 1 : 3 + ($unsigned($random(seed)) % 12);
            i_src.burst(5'h17, n);
            total = total + 16'(n);
            tick(4);
            for (int i = 0; i < 5; i++) begin
                if (i != 3) begin
                    rsel = 3'(i);
                    tick(1);
                    compare(cnt(), total);
                end
            end
        end
        // reload, capture and baud on timers 2-4, each port's baud source in turn
        csel = 5'h00;
        tds = 5'h1f;
        for (int j = 0; j < 2; j++) begin
            run = 5'h00;
            m2 = j[0] ? 2'h2 : 2'h1;
            m4 = j[0] ? 2'h1 : 2'h2;
            // reload kept below all ones, so the next tick cannot wrap again
            v0 = 16'($random(seed)) & 16'h7fff;
            lval = v0;
            rlw = 5'h1c;
            tick(1);
            rlw = 5'h00;
            lval = 16'hfffe;
            lds = 5'h1c;
            tick(1);
            lds = 5'h00;
            run = 5'h1c;
            tick(2);
            compare(16'(ovf), 16'h001c);
            compare(16'({b1, b2}), j[0] ? 16'h0002 : 16'h0001);
            cap = 5'h14;
            rsel = 3'h3;
            tick(1);
            cap = 5'h00;
            compare(cnt(), v0);
            compare(cp2, j[0] ? total : v0);
            compare(cp4, j[0] ? v0 : 16'h0000);
            compare(16'(ovf), 16'h0000);
            total = v0;
        end
        // timer 0 in 13-bit mode, timer 1 in 8-bit reload mode
        run = 5'h00;
        m0 = 2'h0;
        m1 = 2'h2;
        lval = 16'hff1e;
        lds = 5'h01;
        tick(1);
        lval = 16'h40fe;
        lds = 5'h02;
        tick(1);
        lds = 5'h00;
        run = 5'h03;
        tick(2);
        compare(16'(ovf), 16'h0003);
        run = 5'h00;
        rsel = 3'h0;
        tick(1);
        compare(cnt(), 16'h0000);
        rsel = 3'h1;
        tick(1);
        compare(cnt(), 16'h4040);
        // split mode: timer 0 runs two byte counters, timer 1 holds
        m0 = 2'h3;
        m1 = 2'h3;
        lval = 16'h12ff;
        lds = 5'h01;
        tick(1);
        lds = 5'h00;
        run = 5'h03;
        tick(1);
        compare(16'(ovf), 16'h0001);
        run = 5'h00;
        rsel = 3'h0;
        tick(1);
        compare(cnt(), 16'h1300);
        rsel = 3'h1;
        tick(1);
        compare(cnt(), 16'h4040);
        // a reset in mid-run clears counts and captures again
        rst = 1'b1;
        tick(2);
        rst = 1'b0;
        tick(1);
        compare(cnt(), 16'h0000);
        compare(cp4, 16'h0000);
        end_of_test();
    end
endmodule // tb
